// ===== hw/port_mux_pkg.sv
// constants for the port pin function multiplexer
package port_mux_pkg;
    localparam int DATA_W = 8;
    localparam int ADDR_W = 5;
    localparam int TEST_SEL_W = 4;
    localparam int CHAN_W = 5;

    // register offsets
    localparam logic [4:0] ADDR_LATCH_A = 5'h00;
    localparam logic [4:0] ADDR_LATCH_B = 5'h01;
    localparam logic [4:0] ADDR_DIR_A = 5'h02;
    localparam logic [4:0] ADDR_DIR_B = 5'h03;
    localparam logic [4:0] ADDR_ANSEL_A = 5'h04;
    localparam logic [4:0] ADDR_ANSEL_B = 5'h05;
    localparam logic [4:0] ADDR_PULL_A = 5'h06;
    localparam logic [4:0] ADDR_PULL_B = 5'h07;
    localparam logic [4:0] ADDR_CHANGE_EN_A = 5'h08;
    localparam logic [4:0] ADDR_CHANGE_EN_B = 5'h09;
    localparam logic [4:0] ADDR_TEST_BUF = 5'h0a;
    localparam logic [4:0] ADDR_CONV_CTRL0 = 5'h0b;
    localparam logic [4:0] ADDR_MODE_CTRL = 5'h0c;
    localparam logic [4:0] ADDR_PERIPH_CTRL = 5'h0d;
    localparam logic [4:0] ADDR_PINS_A = 5'h0e;
    localparam logic [4:0] ADDR_PINS_B = 5'h0f;
    localparam logic [4:0] ADDR_CHANGE_ST_A = 5'h10;
    localparam logic [4:0] ADDR_CHANGE_ST_B = 5'h11;

    // reset values
    localparam logic [7:0] DIR_RESET = 8'hff;
    localparam logic [7:0] ANSEL_A_RESET = 8'h0f;
    localparam logic [7:0] ANSEL_B_RESET = 8'h36;
    localparam logic [7:0] ZERO_RESET = 8'h00;

    // pin capability masks
    localparam logic [7:0] ANALOG_A_MASK = 8'h0f;
    localparam logic [7:0] ANALOG_B_LARGE_MASK = 8'h36;
    localparam logic [7:0] ANALOG_B_SMALL_MASK = 8'h06;
    localparam logic [7:0] PULL_A_MASK = 8'h23;
    localparam logic [7:0] CSRC_A_MASK = 8'h0c;
    localparam logic [7:0] PULL_B_MASK = 8'hfe;
    localparam logic [7:0] OPEN_DRAIN_A_MASK = 8'h90;
    localparam logic [7:0] OPEN_DRAIN_B_MASK = 8'h01;
    localparam logic [7:0] INPUT_ONLY_A_MASK = 8'h20;

    // field positions
    localparam int TEST_ENABLE_BIT = 7;
    localparam int TEST_SEL_LSB = 0;
    localparam int CHAN_SEL_LSB = 2;
    localparam int CFG_LSB = 0;
    localparam int T0_CLK_SRC_BIT = 0;
    localparam int EXT_INT_EN_BIT = 1;
    localparam int I2C_EN_BIT = 3;
    localparam int MASTER_CLEAR_INPUT_EN_BIT = 4;
    localparam int CAPTURE_EN_BIT = 5;

    // system configuration select codes
    localparam logic [2:0] CFG_STANDALONE = 3'h0;
    localparam logic [2:0] CFG_MULTI_OUT_MASTER = 3'h1;
    localparam logic [2:0] CFG_MULTI_OUT_SLAVE = 3'h2;
    localparam logic [2:0] CFG_MULTI_PHASE_MASTER = 3'h3;
    localparam logic [2:0] CFG_MULTI_PHASE_SLAVE = 3'h4;

    // pin indices with fixed roles
    localparam int PIN_TEST = 0;
    localparam int PIN_SYNC = 1;
    localparam int PIN_T0_INT = 2;
    localparam int PIN_GATE1 = 3;
    localparam int PIN_ALERT = 4;
    localparam int PIN_MASTER_CLEAR_INPUT = 5;
    localparam int PIN_A6 = 6;
    localparam int PIN_SCL = 7;
    localparam int PIN_SDA = 0;
    localparam int PIN_SHARE = 1;
    localparam int PIN_GATE2 = 2;
    localparam int PIN_SWCLK = 3;
    localparam int PIN_B4 = 4;
    localparam int PIN_B5 = 5;
    localparam int PIN_B6 = 6;
endpackage

// ===== hw/port_change_detect.sv
// change detector: flags any level change on enabled pins
`timescale 1ns/100ps
`default_nettype none
module port_change_detect (
    input wire logic clk_in,
    input wire logic resetn_in,
    input wire logic [15:0] level_in,
    input wire logic [15:0] enable_in,
    output logic [15:0] change_out
);
    typedef struct packed {
        logic [15:0] prev;
        logic primed;
    } detect_state_t;

    detect_state_t s_q;
    detect_state_t s_d;

    always_comb begin
        s_d = s_q;
        s_d.prev = level_in;
        s_d.primed = 1'b1;
    end

    always_ff @(posedge clk_in) begin
        if (!resetn_in) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    // no event on the first sample after reset
    assign change_out = (level_in ^ s_q.prev) & enable_in & {16{s_q.primed}};
endmodule
`default_nettype wire

// ===== hw/port_pin_function_mux.sv
// pin function multiplexer for general purpose ports a and b
`timescale 1ns/100ps
`default_nettype none
module port_pin_function_mux (
    input wire logic clk_in,
    input wire logic resetn_in,
    input wire logic [port_mux_pkg::ADDR_W-1:0] addr_in,
    input wire logic [port_mux_pkg::DATA_W-1:0] wdata_in,
    input wire logic wr_in,
    input wire logic rd_in,
    output logic [port_mux_pkg::DATA_W-1:0] rdata_out,
    output logic irq_out,
    input wire logic variant_large_in,
    input wire logic [7:0] pad_a_in,
    output logic [7:0] pad_a_out,
    output logic [7:0] pad_a_oe_out,
    input wire logic [7:0] pad_b_in,
    output logic [7:0] pad_b_out,
    output logic [7:0] pad_b_oe_out,
    output logic [7:0] pullup_a_out,
    output logic [7:0] pullup_b_out,
    output logic [7:0] current_source_a_out,
    output logic [7:0] schmitt_a_out,
    output logic [7:0] schmitt_b_out,
    output logic [7:0] converter_channel_en_out,
    output logic test_out_enable_out,
    output logic [port_mux_pkg::CHAN_W-1:0] analog_test_select_out,
    input wire logic [15:0] digital_test_in,
    input wire logic switching_sync_line_in,
    output logic switching_sync_line_out,
    input wire logic switching_clock_in,
    output logic switching_clock_out,
    output logic shared_current_drive_out,
    output logic shared_current_sense_out,
    output logic timer0_external_clock_out,
    output logic external_interrupt_out,
    output logic timer1_gate_in1_out,
    output logic timer1_gate_in2_out,
    output logic capture_compare_in1_out,
    output logic capture_compare_in2_out,
    input wire logic i2c_scl_pull_low_in,
    input wire logic i2c_sda_pull_low_in,
    output logic i2c_scl_out,
    output logic i2c_sda_out,
    output logic master_clear_active_out,
    input wire logic program_mode_in,
    input wire logic program_data_drive_in,
    input wire logic program_data_oe_in,
    output logic program_data_line_out,
    output logic program_clock_line_out
);
    import port_mux_pkg::*;

    typedef struct packed {
        logic [7:0] lat_a;
        logic [7:0] lat_b;
        logic [7:0] port_a_direction;
        logic [7:0] port_b_direction;
        logic [7:0] ans_a;
        logic [7:0] ans_b;
        logic [7:0] pull_a;
        logic [7:0] pull_b;
        logic [7:0] chg_en_a;
        logic [7:0] chg_en_b;
        logic [7:0] test_buffer_control;
        logic [7:0] converter_control0;
        logic [2:0] system_config_select;
        logic [7:0] periph;
        logic [7:0] chg_st_a;
        logic [7:0] chg_st_b;
        logic [7:0] rdata;
    } mux_state_t;

    mux_state_t s_q;
    mux_state_t s_d;

    ////////////////////////////////////////////////////////////////////////
    // decoded configuration

    logic multi_master;
    logic multi_slave;
    logic multi_any;
    logic phase_master;
    logic phase_slave;
    logic analog_test_enable;
    logic i2c_enable;
    logic master_clear_enable;
    logic capture_enable;
    logic timer0_clock_source_select;
    logic external_interrupt_enable;
    logic [7:0] analog_b_mask;
    logic [7:0] analog_a;
    logic [7:0] analog_b;
    logic [7:0] pins_a;
    logic [7:0] pins_b;
    logic [15:0] change_enable;
    logic [15:0] change_event;
    logic [TEST_SEL_W-1:0] test_sel;

    always_comb begin
        multi_master = (s_q.system_config_select == CFG_MULTI_OUT_MASTER) ||
            (s_q.system_config_select == CFG_MULTI_PHASE_MASTER);
        multi_slave = (s_q.system_config_select == CFG_MULTI_OUT_SLAVE) ||
            (s_q.system_config_select == CFG_MULTI_PHASE_SLAVE);
        multi_any = multi_master || multi_slave;
        phase_master = s_q.system_config_select == CFG_MULTI_PHASE_MASTER;
        phase_slave = s_q.system_config_select == CFG_MULTI_PHASE_SLAVE;
    end

    assign analog_test_enable = s_q.test_buffer_control[TEST_ENABLE_BIT];
    assign test_sel = s_q.test_buffer_control[TEST_SEL_LSB +: TEST_SEL_W];
    assign i2c_enable = s_q.periph[I2C_EN_BIT];
    assign master_clear_enable = s_q.periph[MASTER_CLEAR_INPUT_EN_BIT];
    assign capture_enable = s_q.periph[CAPTURE_EN_BIT] & variant_large_in;
    assign timer0_clock_source_select = s_q.periph[T0_CLK_SRC_BIT];
    assign external_interrupt_enable = s_q.periph[EXT_INT_EN_BIT];
    assign analog_b_mask = variant_large_in ? ANALOG_B_LARGE_MASK :
        ANALOG_B_SMALL_MASK;

    // analog routing needs input direction and analog select
    assign analog_a = s_q.port_a_direction & s_q.ans_a & ANALOG_A_MASK;
    assign analog_b = s_q.port_b_direction & s_q.ans_b & analog_b_mask;
    assign converter_channel_en_out = {analog_b[5:4], analog_b[2:1],
        analog_a[3:0]};

    // digital input buffers read low while pin is analog
    assign pins_a = pad_a_in & ~analog_a;
    assign pins_b = pad_b_in & ~analog_b;

    ////////////////////////////////////////////////////////////////////////
    // pin function overrides

    logic [7:0] ovr_a;
    logic [7:0] ovr_a_oe;
    logic [7:0] ovr_a_val;
    logic [7:0] ovr_b;
    logic [7:0] ovr_b_oe;
    logic [7:0] ovr_b_val;

    always_comb begin
        ovr_a = 8'h00;
        ovr_a_oe = 8'h00;
        ovr_a_val = 8'h00;
        ovr_b = 8'h00;
        ovr_b_oe = 8'h00;
        ovr_b_val = 8'h00;
        if (analog_test_enable) begin
            ovr_a[PIN_TEST] = 1'b1;
            ovr_a_oe[PIN_TEST] = 1'b1;
            ovr_a_val[PIN_TEST] = digital_test_in[test_sel];
        end
        if (multi_any) begin
            ovr_a[PIN_SYNC] = 1'b1;
            ovr_a_oe[PIN_SYNC] = multi_master;
            ovr_a_val[PIN_SYNC] = switching_sync_line_in;
            ovr_b[PIN_SWCLK] = 1'b1;
            ovr_b_oe[PIN_SWCLK] = multi_master;
            ovr_b_val[PIN_SWCLK] = switching_clock_in;
        end
        if (phase_master || phase_slave) begin
            // analog signal: digital driver stays off
            ovr_b[PIN_SHARE] = 1'b1;
        end
        if (i2c_enable) begin
            ovr_a[PIN_SCL] = 1'b1;
            ovr_a_oe[PIN_SCL] = i2c_scl_pull_low_in;
            ovr_b[PIN_SDA] = 1'b1;
            ovr_b_oe[PIN_SDA] = i2c_sda_pull_low_in;
        end
        if (capture_enable) begin
            ovr_a[PIN_A6] = 1'b1;
            ovr_b[PIN_B6] = 1'b1;
        end
        if (program_mode_in && !variant_large_in) begin
            ovr_a[PIN_A6] = 1'b1;
            ovr_a_oe[PIN_A6] = program_data_oe_in;
            ovr_a_val[PIN_A6] = program_data_drive_in;
            ovr_a[PIN_SCL] = 1'b1;
            ovr_a_oe[PIN_SCL] = 1'b0;
        end
        if (program_mode_in && variant_large_in) begin
            ovr_b[PIN_B4] = 1'b1;
            ovr_b_oe[PIN_B4] = program_data_oe_in;
            ovr_b_val[PIN_B4] = program_data_drive_in;
            ovr_b[PIN_B5] = 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // per-pin driver: function override, else general purpose

    genvar gi;
    generate
        for (gi = 0; gi < 8; gi++) begin : g_pin
            logic gp_a_oe;
            logic gp_b_oe;
            // open drain pins only ever pull low
            assign gp_a_oe = OPEN_DRAIN_A_MASK[gi] ?
                (~s_q.port_a_direction[gi] & ~s_q.lat_a[gi]) :
                ~s_q.port_a_direction[gi];
            assign gp_b_oe = OPEN_DRAIN_B_MASK[gi] ?
                (~s_q.port_b_direction[gi] & ~s_q.lat_b[gi]) :
                ~s_q.port_b_direction[gi];
            assign pad_a_oe_out[gi] = INPUT_ONLY_A_MASK[gi] ? 1'b0 :
                (ovr_a[gi] ? ovr_a_oe[gi] : gp_a_oe);
            assign pad_a_out[gi] = OPEN_DRAIN_A_MASK[gi] ? 1'b0 :
                (ovr_a[gi] ? ovr_a_val[gi] : s_q.lat_a[gi]);
            assign pad_b_oe_out[gi] = ovr_b[gi] ? ovr_b_oe[gi] : gp_b_oe;
            assign pad_b_out[gi] = OPEN_DRAIN_B_MASK[gi] ? 1'b0 :
                (ovr_b[gi] ? ovr_b_val[gi] : s_q.lat_b[gi]);
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // pulls, buffer types, peripheral inputs

    always_comb begin
        pullup_a_out = s_q.pull_a & PULL_A_MASK;
        if (master_clear_enable) begin
            pullup_a_out[PIN_MASTER_CLEAR_INPUT] = 1'b1;
        end
        current_source_a_out = s_q.pull_a & CSRC_A_MASK;
        schmitt_a_out = 8'h00;
        schmitt_a_out[PIN_T0_INT] = timer0_clock_source_select |
            external_interrupt_enable;
        schmitt_a_out[PIN_GATE1] = 1'b1;
        schmitt_a_out[PIN_MASTER_CLEAR_INPUT] = master_clear_enable;
        schmitt_a_out[PIN_A6] = 1'b1;
        schmitt_a_out[PIN_SCL] = 1'b1;
        schmitt_b_out = 8'h00;
        schmitt_b_out[PIN_SDA] = i2c_enable;
        schmitt_b_out[PIN_GATE2] = 1'b1;
        schmitt_b_out[PIN_B4] = program_mode_in & variant_large_in;
        schmitt_b_out[PIN_B5] = program_mode_in & variant_large_in;
        schmitt_b_out[PIN_B6] = capture_enable;
    end

    // pull-up of the open drain pins is never offered
    assign pullup_b_out = s_q.pull_b & PULL_B_MASK;

    assign test_out_enable_out = analog_test_enable;
    assign analog_test_select_out =
        s_q.converter_control0[CHAN_SEL_LSB +: CHAN_W];
    assign switching_sync_line_out = multi_slave & pad_a_in[PIN_SYNC];
    assign switching_clock_out = multi_slave & pad_b_in[PIN_SWCLK];
    assign shared_current_drive_out = phase_master;
    assign shared_current_sense_out = phase_slave;
    assign timer0_external_clock_out = timer0_clock_source_select &
        pins_a[PIN_T0_INT];
    assign external_interrupt_out = external_interrupt_enable &
        pins_a[PIN_T0_INT];
    assign timer1_gate_in1_out = pins_a[PIN_GATE1];
    assign timer1_gate_in2_out = pins_b[PIN_GATE2];
    assign capture_compare_in1_out = capture_enable & pad_a_in[PIN_A6];
    assign capture_compare_in2_out = capture_enable & pad_b_in[PIN_B6];
    // idle high when not claimed
    assign i2c_scl_out = i2c_enable ? pad_a_in[PIN_SCL] : 1'b1;
    assign i2c_sda_out = i2c_enable ? pad_b_in[PIN_SDA] : 1'b1;
    assign master_clear_active_out = master_clear_enable &
        ~pad_a_in[PIN_MASTER_CLEAR_INPUT];
    assign program_data_line_out = program_mode_in &
        (variant_large_in ? pad_b_in[PIN_B4] : pad_a_in[PIN_A6]);
    assign program_clock_line_out = program_mode_in &
        (variant_large_in ? pad_b_in[PIN_B5] : pad_a_in[PIN_SCL]);

    ////////////////////////////////////////////////////////////////////////
    // change interrupt

    always_comb begin
        change_enable = {s_q.chg_en_b, s_q.chg_en_a} & ~{analog_b, analog_a};
        if (master_clear_enable) begin
            change_enable[PIN_MASTER_CLEAR_INPUT] = 1'b0;
        end
    end

    port_change_detect u_change (
        .clk_in(clk_in),
        .resetn_in(resetn_in),
        .level_in({pad_b_in, pad_a_in}),
        .enable_in(change_enable),
        .change_out(change_event)
    );

    assign irq_out = |({s_q.chg_st_b, s_q.chg_st_a} &
        {s_q.chg_en_b, s_q.chg_en_a});

    ////////////////////////////////////////////////////////////////////////
    // register file

    always_comb begin
        s_d = s_q;
        if (wr_in) begin
            case (addr_in)
                ADDR_LATCH_A: s_d.lat_a = wdata_in;
                ADDR_LATCH_B: s_d.lat_b = wdata_in;
                ADDR_DIR_A: s_d.port_a_direction = wdata_in;
                ADDR_DIR_B: s_d.port_b_direction = wdata_in;
                ADDR_ANSEL_A: s_d.ans_a = wdata_in;
                ADDR_ANSEL_B: s_d.ans_b = wdata_in;
                ADDR_PULL_A: s_d.pull_a = wdata_in;
                ADDR_PULL_B: s_d.pull_b = wdata_in;
                ADDR_CHANGE_EN_A: s_d.chg_en_a = wdata_in;
                ADDR_CHANGE_EN_B: s_d.chg_en_b = wdata_in;
                ADDR_TEST_BUF: s_d.test_buffer_control = wdata_in;
                ADDR_CONV_CTRL0: s_d.converter_control0 = wdata_in;
                ADDR_MODE_CTRL: s_d.system_config_select =
                    wdata_in[CFG_LSB +: 3];
                ADDR_PERIPH_CTRL: s_d.periph = wdata_in;
                ADDR_CHANGE_ST_A: s_d.chg_st_a = s_q.chg_st_a & ~wdata_in;
                ADDR_CHANGE_ST_B: s_d.chg_st_b = s_q.chg_st_b & ~wdata_in;
                default: s_d = s_q;
            endcase
        end
        // a new change wins over a clear in the same cycle
        s_d.chg_st_a = s_d.chg_st_a | change_event[7:0];
        s_d.chg_st_b = s_d.chg_st_b | change_event[15:8];
        s_d.rdata = 8'h00;
        if (rd_in) begin
            case (addr_in)
                ADDR_LATCH_A: s_d.rdata = s_q.lat_a;
                ADDR_LATCH_B: s_d.rdata = s_q.lat_b;
                ADDR_DIR_A: s_d.rdata = s_q.port_a_direction;
                ADDR_DIR_B: s_d.rdata = s_q.port_b_direction;
                ADDR_ANSEL_A: s_d.rdata = s_q.ans_a;
                ADDR_ANSEL_B: s_d.rdata = s_q.ans_b;
                ADDR_PULL_A: s_d.rdata = s_q.pull_a;
                ADDR_PULL_B: s_d.rdata = s_q.pull_b;
                ADDR_CHANGE_EN_A: s_d.rdata = s_q.chg_en_a;
                ADDR_CHANGE_EN_B: s_d.rdata = s_q.chg_en_b;
                ADDR_TEST_BUF: s_d.rdata = s_q.test_buffer_control;
                ADDR_CONV_CTRL0: s_d.rdata = s_q.converter_control0;
                ADDR_MODE_CTRL: s_d.rdata = {5'h00, s_q.system_config_select};
                ADDR_PERIPH_CTRL: s_d.rdata = s_q.periph;
                ADDR_PINS_A: s_d.rdata = pins_a;
                ADDR_PINS_B: s_d.rdata = pins_b;
                ADDR_CHANGE_ST_A: s_d.rdata = s_q.chg_st_a;
                ADDR_CHANGE_ST_B: s_d.rdata = s_q.chg_st_b;
                default: s_d.rdata = 8'h00;
            endcase
        end
    end

    always_ff @(posedge clk_in) begin
        if (!resetn_in) begin
            s_q <= '0;
            s_q.port_a_direction <= DIR_RESET;
            s_q.port_b_direction <= DIR_RESET;
            s_q.ans_a <= ANSEL_A_RESET;
            s_q.ans_b <= ANSEL_B_RESET;
            s_q.system_config_select <= CFG_STANDALONE;
        end else begin
            s_q <= s_d;
        end
    end

    assign rdata_out = s_q.rdata;
endmodule
`default_nettype wire

// ===== tb/port_mux_monitor.sv
// assertion checker for the port pin function multiplexer
`timescale 1ns/100ps
`default_nettype none
module port_mux_monitor (
    input wire logic clk_in,
    input wire logic resetn_in,
    input wire logic rd_in,
    input wire logic [port_mux_pkg::DATA_W-1:0] rdata_out,
    input wire logic [7:0] pad_a_out,
    input wire logic [7:0] pad_a_oe_out,
    input wire logic [7:0] pullup_a_out,
    input wire logic [7:0] current_source_a_out,
    input wire logic [7:0] converter_channel_en_out,
    input wire logic test_out_enable_out,
    input wire logic master_clear_active_out
);
    import port_mux_pkg::*;
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!resetn_in);
    sequence s_idle;
        !rd_in;
    endsequence
    property p_rd_idle;
        s_idle |=> rdata_out == 8'h00;
    endproperty
    a_rd_idle: assert property (p_rd_idle) else $error("stray read data");
    property p_in_only;
        !pad_a_oe_out[PIN_MASTER_CLEAR_INPUT];
    endproperty
    a_in_only: assert property (p_in_only) else $error("a5 driven");
    property p_od_low;
        (pad_a_oe_out & OPEN_DRAIN_A_MASK & pad_a_out) == 8'h00;
    endproperty
    a_od_low: assert property (p_od_low) else $error("od high");
    property p_pull;
        (pullup_a_out & ~PULL_A_MASK) == 8'h00;
    endproperty
    a_pull: assert property (p_pull) else $error("bad pull-up");
    property p_csrc;
        (current_source_a_out & ~CSRC_A_MASK) == 8'h00;
    endproperty
    a_csrc: assert property (p_csrc) else $error("bad source");
    property p_chan;
        converter_channel_en_out[2] |-> !pad_a_oe_out[2];
    endproperty
    a_chan: assert property (p_chan) else $error("channel on output");
    property p_test;
        test_out_enable_out |-> pad_a_oe_out[PIN_TEST];
    endproperty
    a_test: assert property (p_test) else $error("test not driven");
    property p_master_clear_input;
        master_clear_active_out |-> pullup_a_out[PIN_MASTER_CLEAR_INPUT];
    endproperty
    a_master_clear_input: assert property (p_master_clear_input) else $error("master_clear_input no pull");
endmodule
bind port_pin_function_mux port_mux_monitor mon_u (.clk_in, .resetn_in,
    .rd_in, .rdata_out, .pad_a_out, .pad_a_oe_out, .pullup_a_out,
    .current_source_a_out, .converter_channel_en_out,
    .test_out_enable_out, .master_clear_active_out);
`default_nettype wire

// ===== tb/board_model.sv
// board side of one port: device drive, test drive, board pull-ups
`timescale 1ns/100ps
`default_nettype none
module board_model (
    input wire logic [7:0] oe_in,
    input wire logic [7:0] drive_in,
    input wire logic [7:0] ext_en_in,
    input wire logic [7:0] ext_val_in,
    output logic [7:0] pad_out
);
    // released lines float up to the board pull-up
    always_comb begin
        pad_out = (oe_in & drive_in) | (~oe_in & ext_en_in & ext_val_in)
            | (~oe_in & ~ext_en_in);
    end
endmodule
`default_nettype wire

// ===== tb/tb.sv
// self-checking bench for the port pin function multiplexer
`timescale 1ns/100ps
`default_nettype none
`define CHK(n, e, a) begin n_checks++; if ((a) !== (e)) begin error_cnt++; \
    $display("[ERR] %s exp %h got %h", n, e, a); end end
module tb;
    import port_mux_pkg::*;
    logic clk_in, resetn_in, wr_in, rd_in, irq_out, variant_large_in, mst, slv;
    logic [4:0] addr_in, analog_test_select_out;
    logic [7:0] wdata_in, rdata_out, pad_a_in, pad_a_out, pad_a_oe_out, rd_v;
    logic [7:0] pad_b_in, pad_b_out, pad_b_oe_out, pullup_a_out, pullup_b_out;
    logic [7:0] schmitt_a_out, converter_channel_en_out, ext_a_en, ext_a_val;
    logic [15:0] digital_test_in;
    logic test_out_enable_out, switching_sync_line_in, switching_sync_line_out;
    logic switching_clock_in, shared_current_drive_out, shared_current_sense_out;
    logic timer0_external_clock_out, external_interrupt_out, timer1_gate_in1_out;
    logic i2c_scl_pull_low_in, i2c_sda_pull_low_in, i2c_scl_out;
    logic master_clear_active_out, program_mode_in, program_data_drive_in;
    logic program_data_oe_in, program_clock_line_out;
    int error_cnt = 0;
    int n_checks = 0;
    port_pin_function_mux dut_u (.clk_in, .resetn_in, .addr_in, .wdata_in,
        .wr_in, .rd_in, .rdata_out, .irq_out, .variant_large_in, .pad_a_in,
        .pad_a_out, .pad_a_oe_out, .pad_b_in, .pad_b_out, .pad_b_oe_out,
        .pullup_a_out, .pullup_b_out, .current_source_a_out(), .schmitt_a_out,
        .schmitt_b_out(), .converter_channel_en_out, .test_out_enable_out,
        .analog_test_select_out, .digital_test_in, .switching_sync_line_in,
        .switching_sync_line_out, .switching_clock_in, .switching_clock_out(),
        .shared_current_drive_out, .shared_current_sense_out,
        .timer0_external_clock_out, .external_interrupt_out,
        .timer1_gate_in1_out, .timer1_gate_in2_out(),
        .capture_compare_in1_out(), .capture_compare_in2_out(),
        .i2c_scl_pull_low_in, .i2c_sda_pull_low_in, .i2c_scl_out,
        .i2c_sda_out(), .master_clear_active_out, .program_mode_in,
        .program_data_drive_in, .program_data_oe_in,
        .program_data_line_out(), .program_clock_line_out);
    board_model brd_a_u (.oe_in(pad_a_oe_out), .drive_in(pad_a_out),
        .ext_en_in(ext_a_en), .ext_val_in(ext_a_val), .pad_out(pad_a_in));
    board_model brd_b_u (.oe_in(pad_b_oe_out), .drive_in(pad_b_out),
        .ext_en_in(8'h00), .ext_val_in(8'h00), .pad_out(pad_b_in));
    task automatic wr(input logic [4:0] a, input logic [7:0] d);
        @(posedge clk_in);
        wr_in <= 1'b1;
        addr_in <= a;
        wdata_in <= d;
        @(posedge clk_in);
        wr_in <= 1'b0;
        #1;
    endtask
    task automatic rd(input logic [4:0] a);
        @(posedge clk_in);
        rd_in <= 1'b1;
        addr_in <= a;
        @(posedge clk_in);
        rd_in <= 1'b0;
        #1;
        rd_v = rdata_out;
    endtask
    task automatic drv_a(input logic [7:0] en, input logic [7:0] v);
        @(posedge clk_in);
        ext_a_en <= en;
        ext_a_val <= v;
        #1;
    endtask
    task automatic print_verdict();
        $display("checks %0d errors %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    initial begin
        clk_in = 1'b0;
        forever #4 clk_in = ~clk_in;
    end
    initial begin
        repeat (5000) @(posedge clk_in);
        error_cnt++;
        print_verdict();
    end
    initial begin
        {resetn_in, wr_in, rd_in, switching_sync_line_in} = 4'h0;
        {switching_clock_in, i2c_scl_pull_low_in, i2c_sda_pull_low_in} = 3'h0;
        {program_mode_in, program_data_drive_in, program_data_oe_in} = 3'h0;
        {addr_in, wdata_in, ext_a_en, ext_a_val} = '0;
        variant_large_in = 1'b1;
        digital_test_in = 16'h0008;
        repeat (2) @(posedge clk_in);
        resetn_in <= 1'b1;
        rd(ADDR_DIR_A);
        `CHK("dir a", DIR_RESET, rd_v)
        rd(ADDR_ANSEL_B);
        `CHK("ansel b", ANSEL_B_RESET, rd_v)
        rd(5'h1f);
        `CHK("unmapped", 8'h00, rd_v)
        `CHK("chan", 8'hff, converter_channel_en_out)
        rd(ADDR_PINS_A);
        `CHK("pins a", 8'hf0, rd_v)
        wr(ADDR_DIR_A, 8'h00);
        `CHK("chan out", 8'hf0, converter_channel_en_out)
        `CHK("oe a", 8'hdf, pad_a_oe_out)
        wr(ADDR_LATCH_A, 8'hff);
        `CHK("oe a od", 8'h4f, pad_a_oe_out)
        wr(ADDR_ANSEL_A, 8'h00);
        $display("test direction done");
        wr(ADDR_DIR_A, 8'hfd);
        drv_a(8'h02, 8'h02);
        for (int c = 0; c < 5; c++) begin
            wr(ADDR_MODE_CTRL, 8'(c));
            mst = c == 1 || c == 3;
            slv = c == 2 || c == 4;
            `CHK("sync oe", !slv, pad_a_oe_out[PIN_SYNC])
            `CHK("sync drive", !mst, pad_a_in[PIN_SYNC])
            `CHK("clock oe", mst, pad_b_oe_out[PIN_SWCLK])
            `CHK("share out", c == 3, shared_current_drive_out)
            `CHK("share in", c == 4, shared_current_sense_out)
            if (slv) `CHK("sync in", 1'b1, switching_sync_line_out)
        end
        wr(ADDR_MODE_CTRL, 8'h00);
        $display("test config done");
        wr(ADDR_CONV_CTRL0, 8'h54);
        `CHK("analog sel", 5'h15, analog_test_select_out)
        wr(ADDR_TEST_BUF, 8'h83);
        `CHK("test en", 1'b1, test_out_enable_out)
        `CHK("test drive", 1'b1, pad_a_out[PIN_TEST])
        @(posedge clk_in);
        digital_test_in <= 16'hfff7;
        #1;
        `CHK("test low", 1'b0, pad_a_out[PIN_TEST])
        wr(ADDR_TEST_BUF, 8'h00);
        $display("test analog done");
        wr(ADDR_DIR_A, 8'hff);
        wr(ADDR_PERIPH_CTRL, 8'h03);
        drv_a(8'h0c, 8'h00);
        `CHK("t0 clk", 1'b0, timer0_external_clock_out)
        `CHK("ext int", 1'b0, external_interrupt_out)
        `CHK("gate1", 1'b0, timer1_gate_in1_out)
        `CHK("schmitt", 1'b1, schmitt_a_out[PIN_T0_INT])
        drv_a(8'h0c, 8'h0c);
        `CHK("t0 clk hi", 1'b1, timer0_external_clock_out)
        `CHK("ext int hi", 1'b1, external_interrupt_out)
        wr(ADDR_PERIPH_CTRL, 8'h10);
        wr(ADDR_CHANGE_EN_A, 8'h20);
        drv_a(8'h20, 8'h00);
        @(posedge clk_in);
        #1;
        `CHK("master_clear_input", 1'b1, master_clear_active_out)
        `CHK("master_clear_input pull", 1'b1, pullup_a_out[PIN_MASTER_CLEAR_INPUT])
        rd(ADDR_CHANGE_ST_A);
        `CHK("master_clear_input ioc", 8'h00, rd_v)
        wr(ADDR_CHANGE_EN_A, 8'h10);
        drv_a(8'h10, 8'h00);
        @(posedge clk_in);
        #1;
        `CHK("irq set", 1'b1, irq_out)
        rd(ADDR_CHANGE_ST_A);
        `CHK("status", 8'h10, rd_v)
        wr(ADDR_CHANGE_ST_A, 8'h10);
        `CHK("irq clr", 1'b0, irq_out)
        $display("test change done");
        wr(ADDR_PERIPH_CTRL, 8'h08);
        @(posedge clk_in);
        i2c_scl_pull_low_in <= 1'b1;
        #1;
        `CHK("scl oe", 1'b1, pad_a_oe_out[PIN_SCL])
        `CHK("scl line", 1'b0, i2c_scl_out)
        @(posedge clk_in);
        {i2c_scl_pull_low_in, variant_large_in} <= 2'h0;
        {program_mode_in, program_data_oe_in} <= 2'h3;
        #1;
        `CHK("scl rel", 1'b0, pad_a_oe_out[PIN_SCL])
        `CHK("pgm oe", 1'b1, pad_a_oe_out[PIN_A6])
        `CHK("pgm data", 1'b0, pad_a_out[PIN_A6])
        `CHK("pgm clk", 1'b1, program_clock_line_out)
        @(posedge clk_in);
        variant_large_in <= 1'b1;
        #1;
        `CHK("pgm oe b4", 1'b1, pad_b_oe_out[PIN_B4])
        $display("test pins done");
        print_verdict();
    end
endmodule
`default_nettype wire
